// *** slpr_pkg.sv ***
/*
 * Shared constants for the link parameter register bank: byte offsets,
 * field positions, fixed read-only values and reset values.
 * Assumes an 8-bit register port with 12-bit byte addresses.
 */
package slpr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [11:0] OFS_SUBCLASS_AND_SAMPLE_BITS  = 12'h458;
  localparam logic [11:0] OFS_VERSION_AND_SAMPLES       = 12'h459;
  localparam logic [11:0] OFS_DENSITY_AND_CONTROL_WORDS = 12'h45a;
  localparam logic [11:0] OFS_SPARE_LINK_BYTE_ONE       = 12'h45b;
  localparam logic [11:0] OFS_SPARE_LINK_BYTE_TWO       = 12'h45c;
  localparam logic [11:0] OFS_LINK_CONFIG_CHECKSUM      = 12'h45d;
  localparam logic [11:0] OFS_PER_LANE_ALIGNMENT_STATUS = 12'h46c;

  // Field positions
  localparam int unsigned UPPER_LSB        = 5;
  localparam int unsigned UPPER_MSB        = 7;
  localparam int unsigned LOWER_MSB        = 4;
  localparam int unsigned HIGH_DENSITY_BIT = 7;
  localparam int unsigned LANE6_BIT        = 6;

  // Fixed read-only field values, minus-one encoded where applicable
  localparam logic [4:0] RESOLUTION_M1      = 5'h0f;
  localparam logic [4:0] BITS_PER_SAMPLE_M1 = 5'h0f;
  localparam logic [4:0] SAMPLES_PER_FRAME_M1 = 5'h01;
  localparam logic [0:0] HIGH_DENSITY_VAL   = 1'h1;
  localparam logic [4:0] CONTROL_WORDS_VAL  = 5'h00;

  // Subclass and version codes
  localparam logic [2:0] SUBCLASS_0   = 3'h0;
  localparam logic [2:0] SUBCLASS_1   = 3'h1;
  localparam logic [2:0] VERSION_A    = 3'h0;
  localparam logic [2:0] VERSION_B    = 3'h1;

  // Reset values
  localparam logic [2:0] SUBCLASS_RST = 3'h0;
  localparam logic [2:0] VERSION_RST  = 3'h0;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;

endpackage : slpr_pkg

// *** slpr_if.sv ***
/*
 * Link between host software / link transmitter and the register bank.
 * Assumes both ends share ref_clk_i; no clocking block.
 */
`timescale 1ns/1ns
interface slpr_if;
  logic [11:0] reg_addr;       // Byte address
  logic        reg_wr;         // Write strobe, one cycle
  logic        reg_rd;         // Read strobe, one cycle
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;     // Read answer, one cycle
  logic        deframer_soft_rst; // Deframer held in soft reset
  logic        skip_alignment_sequence;
  logic        ilas_sent;      // Transmitter finished alignment sequence

  modport device (
    input  reg_addr, reg_wr, reg_rd, reg_wdata,
    input  deframer_soft_rst, skip_alignment_sequence, ilas_sent,
    output reg_rdata, reg_rvalid
  );

  modport host (
    output reg_addr, reg_wr, reg_rd, reg_wdata,
    output deframer_soft_rst, skip_alignment_sequence, ilas_sent,
    input  reg_rdata, reg_rvalid
  );
endinterface : slpr_if

// *** slpr_host.sv ***
/*
 * Host end: programs the link parameter bank under deframer soft reset,
 * computes the checksum, then acts as transmitter sending the alignment
 * sequence. Also offers single register reads.
 * Assumes the device end answers reads one cycle after the strobe.
 */
`timescale 1ns/1ns
module slpr_host (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  slpr_if.host             link,
  input  wire logic        cfg_start_i,
  input  wire logic [2:0]  cfg_subclass_i,
  input  wire logic [2:0]  cfg_version_i,
  input  wire logic [7:0]  cfg_spare_one_i,
  input  wire logic [7:0]  cfg_spare_two_i,
  input  wire logic [7:0]  cfg_other_sum_i,
  input  wire logic        cfg_skip_align_i,
  input  wire logic        rd_req_i,
  input  wire logic [11:0] rd_addr_i,
  output logic             busy_o,
  output logic             cfg_error_o,
  output logic             cfg_done_o,
  output logic [7:0]       rd_data_o,
  output logic             rd_valid_o
);

  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_RST_ON  = 9'h002,
    ST_WR_SUB  = 9'h004,
    ST_WR_VER  = 9'h008,
    ST_WR_SP1  = 9'h010,
    ST_WR_SP2  = 9'h020,
    ST_WR_SUM  = 9'h040,
    ST_RST_OFF = 9'h080,
    ST_ILAS    = 9'h100
  } slpr_host_state_t;

  // Checksum over field values, modulo 256 by truncation
  function automatic logic [7:0] field_sum(input logic [2:0] sub, input logic [2:0] ver,
                                           input logic [7:0] s1, input logic [7:0] s2,
                                           input logic [7:0] other);
    field_sum = other + {5'h00, sub} + {3'h0, slpr_pkg::BITS_PER_SAMPLE_M1}
              + {5'h00, ver} + {3'h0, slpr_pkg::SAMPLES_PER_FRAME_M1}
              + {7'h00, slpr_pkg::HIGH_DENSITY_VAL} + {3'h0, slpr_pkg::CONTROL_WORDS_VAL}
              + s1 + s2;
  endfunction : field_sum

  slpr_host_state_t state,      next_state;
  logic [11:0]      addr,       next_addr;
  logic             wr,         next_wr;
  logic             rd,         next_rd;
  logic [7:0]       wdata,      next_wdata;
  logic             soft_rst,   next_soft_rst;
  logic             skip,       next_skip;
  logic             ilas,       next_ilas;
  logic             error,      next_error;
  logic             done,       next_done;
  logic [7:0]       rdata,      next_rdata;
  logic             rvalid,     next_rvalid;
  logic [2:0]       sub,        next_sub;
  logic [2:0]       ver,        next_ver;
  logic [7:0]       sp1,        next_sp1;
  logic [7:0]       sp2,        next_sp2;
  logic [7:0]       osum,       next_osum;
  logic             busy,       next_busy;

  always_comb begin
    next_state    = state;
    next_addr     = addr;
    next_wr       = 1'b0;
    next_rd       = 1'b0;
    next_wdata    = wdata;
    next_soft_rst = soft_rst;
    next_skip     = skip;
    next_ilas     = 1'b0;
    next_error    = error;
    next_done     = 1'b0;
    next_rdata    = rdata;
    next_rvalid   = link.reg_rvalid;
    next_sub      = sub;
    next_ver      = ver;
    next_sp1      = sp1;
    next_sp2      = sp2;
    next_osum     = osum;
    if (link.reg_rvalid) begin
      next_rdata = link.reg_rdata;
    end
    unique case (state)
      ST_IDLE: begin
        if (cfg_start_i) begin
          if (cfg_subclass_i > slpr_pkg::SUBCLASS_1) begin
            next_error = 1'b1;
          end else begin
            next_error = 1'b0;
            next_sub   = cfg_subclass_i;
            next_ver   = cfg_version_i;
            next_sp1   = cfg_spare_one_i;
            next_sp2   = cfg_spare_two_i;
            next_osum  = cfg_other_sum_i;
            next_skip  = cfg_skip_align_i;
            next_state = ST_RST_ON;
          end
        end else if (rd_req_i) begin
          next_rd   = 1'b1;
          next_addr = rd_addr_i;
        end
      end
      ST_RST_ON: begin
        next_soft_rst = 1'b1;
        next_state    = ST_WR_SUB;
      end
      ST_WR_SUB: begin
        next_wr    = 1'b1;
        next_addr  = slpr_pkg::OFS_SUBCLASS_AND_SAMPLE_BITS;
        next_wdata = {sub, slpr_pkg::BITS_PER_SAMPLE_M1};
        next_state = ST_WR_VER;
      end
      ST_WR_VER: begin
        next_wr    = 1'b1;
        next_addr  = slpr_pkg::OFS_VERSION_AND_SAMPLES;
        next_wdata = {ver, slpr_pkg::SAMPLES_PER_FRAME_M1};
        next_state = ST_WR_SP1;
      end
      ST_WR_SP1: begin
        next_wr    = 1'b1;
        next_addr  = slpr_pkg::OFS_SPARE_LINK_BYTE_ONE;
        next_wdata = sp1;
        next_state = ST_WR_SP2;
      end
      ST_WR_SP2: begin
        next_wr    = 1'b1;
        next_addr  = slpr_pkg::OFS_SPARE_LINK_BYTE_TWO;
        next_wdata = sp2;
        next_state = ST_WR_SUM;
      end
      ST_WR_SUM: begin
        next_wr    = 1'b1;
        next_addr  = slpr_pkg::OFS_LINK_CONFIG_CHECKSUM;
        next_wdata = field_sum(sub, ver, sp1, sp2, osum);
        next_state = ST_RST_OFF;
      end
      ST_RST_OFF: begin
        // Release only after the last write has landed
        next_soft_rst = 1'b0;
        next_state    = ST_ILAS;
      end
      ST_ILAS: begin
        next_ilas  = 1'b1;
        next_done  = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state    <= ST_IDLE;
      addr     <= 12'h000;
      wr       <= 1'b0;
      rd       <= 1'b0;
      wdata    <= slpr_pkg::BYTE_RST;
      soft_rst <= 1'b0;
      skip     <= 1'b0;
      ilas     <= 1'b0;
      error    <= 1'b0;
      done     <= 1'b0;
      rdata    <= slpr_pkg::BYTE_RST;
      rvalid   <= 1'b0;
      sub      <= slpr_pkg::SUBCLASS_RST;
      ver      <= slpr_pkg::VERSION_RST;
      sp1      <= slpr_pkg::BYTE_RST;
      sp2      <= slpr_pkg::BYTE_RST;
      osum     <= slpr_pkg::BYTE_RST;
      busy     <= 1'b0;
    end else begin
      state    <= next_state;
      addr     <= next_addr;
      wr       <= next_wr;
      rd       <= next_rd;
      wdata    <= next_wdata;
      soft_rst <= next_soft_rst;
      skip     <= next_skip;
      ilas     <= next_ilas;
      error    <= next_error;
      done     <= next_done;
      rdata    <= next_rdata;
      rvalid   <= next_rvalid;
      sub      <= next_sub;
      ver      <= next_ver;
      sp1      <= next_sp1;
      sp2      <= next_sp2;
      osum     <= next_osum;
      busy     <= next_busy;
    end
  end

  assign link.reg_addr                = addr;
  assign link.reg_wr                  = wr;
  assign link.reg_rd                  = rd;
  assign link.reg_wdata               = wdata;
  assign link.deframer_soft_rst       = soft_rst;
  assign link.skip_alignment_sequence = skip;
  assign link.ilas_sent               = ilas;
  assign busy_o      = busy;
  assign cfg_error_o = error;
  assign cfg_done_o  = done;
  assign rd_data_o   = rdata;
  assign rd_valid_o  = rvalid;

endmodule : slpr_host

// *** slpr_device.sv ***
/*
 * Device end: link parameter register bank of a multi-lane serial
 * receiver. Holds the programmable link parameters, fixed read-only
 * fields and per-lane alignment status.
 * Assumes a byte-wide register port on the shared clock, and lane
 * results delivered by the deframer datapath on the user side.
 * Writes are not gated by the soft reset: the host keeps that order.
 * Subclass codes above one are dropped without any indication.
 * Only the low eight lanes are visible in the status byte.
 */
// Overview of operation
// - Resolution field reads fixed sixteen minus one; no address of this bank reads it, the value is only kept in RESOLUTION_FIELD
// - Subclass field accepts zero or one only
// - Parameters written only under deframer soft reset; the device takes writes at any time, and the host keeps the order
// - Bits-per-sample field reads fixed sixteen minus one
// - Version field writable, zero is earlier revision
// - Samples-per-frame field read-only, minus one
// - High-density bit read-only, resets to one
// - Control-word count reads as zero
// - Two spare bytes writable, reset to zero
// - Software writes field-sum checksum modulo 256
// - One deskew status bit per lane
// - Bit six reports lane six synchronisation

`timescale 1ns/1ns
module slpr_device #(
  parameter int unsigned LANES = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  slpr_if.device                link,
  input  wire logic [LANES-1:0] lane_status_i,
  input  wire logic             lane_status_valid_i,
  output logic [2:0]            link_subclass_field_o,
  output logic [2:0]            standard_version_field_o,
  output logic [7:0]            spare_field_one_o,
  output logic [7:0]            spare_field_two_o,
  output logic [7:0]            checksum_o,
  output logic                  deframer_in_reset_o,
  output logic [LANES-1:0]      lane_status_o
);

  // Subclass 2 and above are not supported; such writes keep the old value
  function automatic logic subclass_legal(input logic [2:0] code);
    subclass_legal = (code == slpr_pkg::SUBCLASS_0) || (code == slpr_pkg::SUBCLASS_1);
  endfunction : subclass_legal

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Upper three-bit field over the lower five-bit field, reserved bits zero
  function automatic logic [7:0] pack_fields(input logic [2:0] upper, input logic [4:0] lower);
    pack_fields                                          = slpr_pkg::READ_ZERO;
    pack_fields[slpr_pkg::UPPER_MSB:slpr_pkg::UPPER_LSB] = upper;
    pack_fields[slpr_pkg::LOWER_MSB:0]                   = lower;
  endfunction : pack_fields

  // Lane n shows in bit n; lanes past the byte are not visible here
  function automatic logic [7:0] status_byte(input logic [LANES-1:0] lanes_ok);
    status_byte = slpr_pkg::READ_ZERO;
    for (int n = 0; n < LANES && n < slpr_pkg::DATA_W; n++) begin
      status_byte[n] = lanes_ok[n];
    end
  endfunction : status_byte

  logic [2:0]       subclass,   next_subclass;
  logic [2:0]       version,    next_version;
  logic [7:0]       spare_one,  next_spare_one;
  logic [7:0]       spare_two,  next_spare_two;
  logic [7:0]       checksum,   next_checksum;
  logic [LANES-1:0] status,     next_status;
  logic             pending,    next_pending;
  logic             in_reset,   next_in_reset;
  logic [7:0]       rdata,      next_rdata;
  logic             rvalid,     next_rvalid;

  // Register writes
  always_comb begin
    next_subclass  = subclass;
    next_version   = version;
    next_spare_one = spare_one;
    next_spare_two = spare_two;
    next_checksum  = checksum;
    // Writes outside soft reset are still taken; host must avoid them
    if (link.reg_wr) begin
      if (hit(link.reg_addr, slpr_pkg::OFS_SUBCLASS_AND_SAMPLE_BITS)
          && subclass_legal(link.reg_wdata[slpr_pkg::UPPER_MSB:slpr_pkg::UPPER_LSB])) begin
        next_subclass = link.reg_wdata[slpr_pkg::UPPER_MSB:slpr_pkg::UPPER_LSB];
      end
      if (hit(link.reg_addr, slpr_pkg::OFS_VERSION_AND_SAMPLES)) begin
        next_version = link.reg_wdata[slpr_pkg::UPPER_MSB:slpr_pkg::UPPER_LSB];
      end
      if (hit(link.reg_addr, slpr_pkg::OFS_SPARE_LINK_BYTE_ONE)) begin
        next_spare_one = link.reg_wdata;
      end
      if (hit(link.reg_addr, slpr_pkg::OFS_SPARE_LINK_BYTE_TWO)) begin
        next_spare_two = link.reg_wdata;
      end
      if (hit(link.reg_addr, slpr_pkg::OFS_LINK_CONFIG_CHECKSUM)) begin
        next_checksum = link.reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      subclass  <= slpr_pkg::SUBCLASS_RST;
      version   <= slpr_pkg::VERSION_RST;
      spare_one <= slpr_pkg::BYTE_RST;
      spare_two <= slpr_pkg::BYTE_RST;
      checksum  <= slpr_pkg::BYTE_RST;
    end else begin
      subclass  <= next_subclass;
      version   <= next_version;
      spare_one <= next_spare_one;
      spare_two <= next_spare_two;
      checksum  <= next_checksum;
    end
  end

  // Lane status: cleared while in soft reset, armed by a new sequence
  // Skip option not used: software disregards these bits when it is set
  always_comb begin
    next_in_reset = link.deframer_soft_rst;
    next_status   = status;
    next_pending  = pending;
    if (link.deframer_soft_rst) begin
      next_status  = '0;
      next_pending = 1'b0;
    end else begin
      if (link.ilas_sent) begin
        next_pending = 1'b1;
      end
      // Result counts only once the sequence has been sent again
      // A result in the same cycle as the sequence uses that arm at once
      if (lane_status_valid_i && (pending || link.ilas_sent)) begin
        next_status  = lane_status_i;
        next_pending = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status   <= slpr_pkg::STATUS_RST[LANES-1:0];
      pending  <= 1'b0;
      in_reset <= 1'b0;
    end else begin
      status   <= next_status;
      pending  <= next_pending;
      in_reset <= next_in_reset;
    end
  end

  // Read mux, answered one cycle after the strobe
  always_comb begin
    next_rvalid = link.reg_rd;
    next_rdata  = rdata;
    if (link.reg_rd) begin
      unique case (link.reg_addr)
        slpr_pkg::OFS_SUBCLASS_AND_SAMPLE_BITS:
          next_rdata = pack_fields(subclass, slpr_pkg::BITS_PER_SAMPLE_M1);
        slpr_pkg::OFS_VERSION_AND_SAMPLES:
          next_rdata = pack_fields(version, slpr_pkg::SAMPLES_PER_FRAME_M1);
        slpr_pkg::OFS_DENSITY_AND_CONTROL_WORDS:
          next_rdata = pack_fields({slpr_pkg::HIGH_DENSITY_VAL, 2'h0},
                                   slpr_pkg::CONTROL_WORDS_VAL);
        slpr_pkg::OFS_SPARE_LINK_BYTE_ONE:
          next_rdata = spare_one;
        slpr_pkg::OFS_SPARE_LINK_BYTE_TWO:
          next_rdata = spare_two;
        slpr_pkg::OFS_LINK_CONFIG_CHECKSUM:
          next_rdata = checksum;
        slpr_pkg::OFS_PER_LANE_ALIGNMENT_STATUS:
          next_rdata = status_byte(status);
        default:
          next_rdata = slpr_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata  <= slpr_pkg::READ_ZERO;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Resolution field lives in the register below this bank; kept for users
  localparam logic [4:0] RESOLUTION_FIELD = slpr_pkg::RESOLUTION_M1;

  assign link.reg_rdata           = rdata;
  assign link.reg_rvalid          = rvalid;
  assign link_subclass_field_o    = subclass;
  assign standard_version_field_o = version;
  assign spare_field_one_o        = spare_one;
  assign spare_field_two_o        = spare_two;
  assign checksum_o               = checksum;
  assign deframer_in_reset_o      = in_reset;
  assign lane_status_o            = status;

endmodule : slpr_device

// *** slpr_sva.sv ***
/*
 * Checker for the register port and link control lines of slpr_if.
 * Assumes one clock domain, ref_clk_i, with rstn_i as async active-low reset.
 */
`timescale 1ns/1ns
module slpr_sva (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        deframer_soft_rst,
  input wire logic        skip_alignment_sequence,
  input wire logic        ilas_sent
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_read_answered: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  a_answer_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without strobe");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_sample_bits_ro: assert property (
    reg_rd && reg_addr == slpr_pkg::OFS_SUBCLASS_AND_SAMPLE_BITS
    |=> reg_rdata[4:0] == 5'h0f) else $error("bits per sample field wrong");
  a_samples_frame_ro: assert property (
    reg_rd && reg_addr == slpr_pkg::OFS_VERSION_AND_SAMPLES
    |=> reg_rdata[4:0] == 5'h01) else $error("samples per frame field wrong");
  a_density_ctl_ro: assert property (
    reg_rd && reg_addr == slpr_pkg::OFS_DENSITY_AND_CONTROL_WORDS
    |=> reg_rdata == 8'h80) else $error("density byte wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h45e |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_write_in_reset: assert property (reg_wr |-> deframer_soft_rst)
    else $error("parameter write outside soft reset");
  a_subclass_legal: assert property (
    reg_wr && reg_addr == slpr_pkg::OFS_SUBCLASS_AND_SAMPLE_BITS
    |-> reg_wdata[7:5] <= 3'h1) else $error("unsupported subclass written");
  a_ilas_after_cfg: assert property (ilas_sent |-> !deframer_soft_rst && !reg_wr)
    else $error("alignment sequence sent during configuration");
endmodule : slpr_sva

// *** tb_top.sv ***
/*
 * Testbench joining host and device ends over slpr_if; drives the host's
 * user side and the device's lane results, and reads back through the host.
 * Assumes the host answers reads three cycles after the request.
 */
`timescale 1ns/1ns
module tb_top;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        cfg_start_i = 1'b0;
  logic [2:0]  cfg_subclass_i = 3'h0;
  logic [2:0]  cfg_version_i = 3'h0;
  logic [7:0]  cfg_spare_one_i = 8'h00;
  logic [7:0]  cfg_spare_two_i = 8'h00;
  logic [7:0]  cfg_other_sum_i = 8'h00;
  logic        cfg_skip_align_i = 1'b0;
  logic        rd_req_i = 1'b0;
  logic [11:0] rd_addr_i = 12'h000;
  logic [7:0]  lane_status_i = 8'h00;
  logic        lane_status_valid_i = 1'b0;
  logic        busy_o, cfg_error_o, cfg_done_o, rd_valid_o, deframer_in_reset_o;
  logic [7:0]  rd_data_o, spare_field_one_o, spare_field_two_o, checksum_o, lane_status_o;
  logic [2:0]  link_subclass_field_o, standard_version_field_o;
  int          miscompares = 0;
  int          check_count = 0;
  int          ilas_count = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  slpr_if link ();

  slpr_host i_slpr_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link),
    .cfg_start_i(cfg_start_i), .cfg_subclass_i(cfg_subclass_i),
    .cfg_version_i(cfg_version_i), .cfg_spare_one_i(cfg_spare_one_i),
    .cfg_spare_two_i(cfg_spare_two_i), .cfg_other_sum_i(cfg_other_sum_i),
    .cfg_skip_align_i(cfg_skip_align_i), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i),
    .busy_o(busy_o), .cfg_error_o(cfg_error_o), .cfg_done_o(cfg_done_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));

  slpr_device #(.LANES(8)) i_slpr_device (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .link(link), .lane_status_i(lane_status_i), .lane_status_valid_i(lane_status_valid_i),
    .link_subclass_field_o(link_subclass_field_o),
    .standard_version_field_o(standard_version_field_o),
    .spare_field_one_o(spare_field_one_o), .spare_field_two_o(spare_field_two_o),
    .checksum_o(checksum_o), .deframer_in_reset_o(deframer_in_reset_o),
    .lane_status_o(lane_status_o));

  slpr_sva i_slpr_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr(link.reg_addr),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid),
    .deframer_soft_rst(link.deframer_soft_rst),
    .skip_alignment_sequence(link.skip_alignment_sequence), .ilas_sent(link.ilas_sent));

  always @(negedge ref_clk_i) begin
    if (link.ilas_sent === 1'b1) ilas_count++;
  end

  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Field sums only, read-only fields included, wrapped to a byte
  function automatic logic [7:0] csum(input logic [2:0] sub, input logic [2:0] ver,
                                      input logic [7:0] s1, input logic [7:0] s2,
                                      input logic [7:0] oth);
    return oth + {5'h00, sub} + 8'h0f + {5'h00, ver} + 8'h01 + 8'h01 + 8'h00 + s1 + s2;
  endfunction : csum

  task automatic rd(input logic [11:0] addr, input logic [7:0] exp);
    int n;
    for (n = 0; n < 20 && busy_o !== 1'b0; n++) @(posedge ref_clk_i) #1;
    rd_addr_i = addr;
    rd_req_i = 1'b1;
    @(posedge ref_clk_i) #1;
    rd_req_i = 1'b0;
    for (n = 0; n < 10 && rd_valid_o !== 1'b1; n++) @(posedge ref_clk_i) #1;
    chk({7'h00, rd_valid_o}, 8'h01, "read answer");
    chk(rd_data_o, exp, "register read");
  endtask : rd

  task automatic prog(input logic [2:0] sub, input logic [2:0] ver, input logic [7:0] s1,
                      input logic [7:0] s2, input logic [7:0] oth, input logic exp_err);
    int   n;
    logic done;
    logic err;
    done = 1'b0;
    err = 1'b0;
    @(posedge ref_clk_i) #1;
    {cfg_subclass_i, cfg_version_i, cfg_spare_one_i, cfg_spare_two_i} = {sub, ver, s1, s2};
    cfg_other_sum_i = oth;
    cfg_start_i = 1'b1;
    @(posedge ref_clk_i) #1;
    cfg_start_i = 1'b0;
    for (n = 0; n < 20 && !done && !err; n++) begin
      @(posedge ref_clk_i) #1;
      done = (cfg_done_o === 1'b1);
      err = (cfg_error_o === 1'b1);
    end
    chk({6'h00, err, done}, exp_err ? 8'h02 : 8'h01, "configuration end");
  endtask : prog

  task automatic lane(input logic [7:0] val);
    @(posedge ref_clk_i) #1;
    lane_status_i = val;
    lane_status_valid_i = 1'b1;
    @(posedge ref_clk_i) #1;
    lane_status_valid_i = 1'b0;
  endtask : lane

  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    lane(8'hff);
    rd(12'h458, 8'h0f);
    rd(12'h459, 8'h01);
    rd(12'h45a, 8'h80);
    rd(12'h45b, 8'h00);
    rd(12'h45c, 8'h00);
    rd(12'h45d, 8'h00);
    rd(12'h46c, 8'h00);
    rd(12'h45e, 8'h00);
    prog(3'h1, 3'h1, 8'ha5, 8'hff, 8'h23, 1'b0);
    @(posedge ref_clk_i) #1;
    chk(8'(ilas_count), 8'h01, "alignment sequences");
    rd(12'h458, 8'h2f);
    rd(12'h459, 8'h21);
    rd(12'h45b, 8'ha5);
    rd(12'h45c, 8'hff);
    rd(12'h45d, csum(3'h1, 3'h1, 8'ha5, 8'hff, 8'h23));
    chk(checksum_o, csum(3'h1, 3'h1, 8'ha5, 8'hff, 8'h23), "checksum output");
    lane(8'h5a);
    rd(12'h46c, 8'h5a);
    chk(lane_status_o, 8'h5a, "lane status output");
    lane(8'h0f);
    rd(12'h46c, 8'h5a);
    prog(3'h2, 3'h1, 8'h00, 8'h00, 8'h00, 1'b1);
    rd(12'h458, 8'h2f);
    prog(3'h0, 3'h0, 8'h00, 8'h5a, 8'h00, 1'b0);
    rd(12'h46c, 8'h00);
    rd(12'h458, 8'h0f);
    rd(12'h459, 8'h01);
    chk({5'h00, standard_version_field_o}, 8'h00, "version output");
    rd(12'h45c, 8'h5a);
    rd(12'h45d, csum(3'h0, 3'h0, 8'h00, 8'h5a, 8'h00));
    lane(8'h40);
    rd(12'h46c, 8'h40);
    chk(8'(ilas_count), 8'h02, "alignment sequences");
    give_verdict();
  end

  // Whole sequence needs well under 1000 cycles
  initial begin
    #(50 * 4000);
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
